//--- hw/irq_ctl_defines.svh
// Offsets, field positions, reset values and timing counts of the interrupt control block.
`ifndef IRQ_CTL_DEFINES_SVH
`define IRQ_CTL_DEFINES_SVH

`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_MASK        8'h08
`define OFS_CORE        8'h0C
`define OFS_LEVEL       8'h10

`define BIT_GIE         15
`define BIT_HOLDOFF     14
`define BIT_SOFT_TRAP_FLAG      13
`define CTRL_RESET      16'h8000
`define CTRL_WMASK      16'hA007

`define STAT_TRAP       3
`define NUM_EXT         3
`define NUM_EVENTS      4
`define HOLDOFF_MAX     16'hFFFF

`endif

//--- hw/irq_ctl_pkg.sv
// Types shared by the interrupt control block.
package irq_ctl_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ
  } bus_phase_t;
endpackage

//--- hw/ext_edge_detect.sv
// Synchronises one external interrupt pin and detects the selected edge.
module ext_edge_detect (
  // Clock and reset.
  input  wire logic CLK_I,
  input  wire logic RST_I,
  // Pin and polarity.
  input  wire logic pin_i,
  input  wire logic falling_sel_i,
  // Detected edge.
  output logic      edge_o
);
  logic sync1_reg;
  logic sync2_reg;
  logic last_reg;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg  <= 1'b0;
    end else begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
    end
  end

  // A one selects the falling edge, a zero the rising edge.
  assign edge_o = falling_sel_i ? (last_reg & ~sync2_reg) : (~last_reg & sync2_reg);
endmodule

//--- hw/irq_ctl.sv
// Interrupt enable, hold-off, soft trap, edge polarity and priority level control over AHB-Lite.
`include "irq_ctl_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module irq_ctl #(
  parameter int NUM_EXT = `NUM_EXT
) (
  // Clock and reset.
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // AHB-Lite slave.
  input  wire logic        HSEL_I,
  input  wire logic [7:0]  HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic [31:0]      HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  // External interrupt pins.
  input  wire logic [2:0]  EXT_IRQ_I,
  // Core side.
  input  wire logic [2:0]  CPU_STATUS_PRIO_I,
  input  wire logic        HOLDOFF_START_I,
  input  wire logic [15:0] HOLDOFF_COUNT_I,
  // Outputs to the core.
  output logic [3:0]       PRIO_LEVEL_O,
  output logic             TRAP_REQ_O,
  output logic             IRQ_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase capture.
  irq_ctl_pkg::bus_phase_t phase_reg;
  logic [7:0]  addr_reg;
  logic [15:0] ctrl_reg;
  logic [3:0]  status_reg;
  logic [3:0]  mask_reg;
  logic        prio_level_top_bit;
  logic [15:0] holdoff_cnt_reg;
  logic [NUM_EXT-1:0] edge_hit;
  logic [3:0]  event_set;
  logic        wr_ctrl;
  logic        wr_status;
  logic        wr_mask;
  logic        wr_core;
  logic        irq_holdoff_active;
  logic [31:0] rdata_next;

  wire start_xfer = HSEL_I & HREADY_I & HTRANS_I[1];

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      phase_reg <= irq_ctl_pkg::BUS_IDLE;
      addr_reg  <= 8'h00;
    end else if (start_xfer) begin
      phase_reg <= HWRITE_I ? irq_ctl_pkg::BUS_WRITE : irq_ctl_pkg::BUS_READ;
      addr_reg  <= HADDR_I;
    end else begin
      phase_reg <= irq_ctl_pkg::BUS_IDLE;
    end
  end

  always_comb begin
    wr_ctrl   = 1'b0;
    wr_status = 1'b0;
    wr_mask   = 1'b0;
    wr_core   = 1'b0;
    case (phase_reg)
      irq_ctl_pkg::BUS_WRITE: begin
        wr_ctrl   = (addr_reg == `OFS_CTRL);
        wr_status = (addr_reg == `OFS_STATUS);
        wr_mask   = (addr_reg == `OFS_MASK);
        wr_core   = (addr_reg == `OFS_CORE);
      end
      default: begin
        wr_ctrl = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and hold-off counter.
  assign irq_holdoff_active = (holdoff_cnt_reg != 16'h0000);

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= HWDATA_I[15:0] & `CTRL_WMASK;
    end
  end

  // The counter runs one cycle per unit so software sees the hold-off end on its own.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      holdoff_cnt_reg <= 16'h0000;
    end else if (HOLDOFF_START_I) begin
      holdoff_cnt_reg <= HOLDOFF_COUNT_I;
    end else if (irq_holdoff_active) begin
      holdoff_cnt_reg <= holdoff_cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      prio_level_top_bit <= 1'b0;
    end else if (wr_core) begin
      prio_level_top_bit <= HWDATA_I[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection per pin.
  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : g_ext
      ext_edge_detect u_edge (
        .CLK_I         (CLK_I),
        .RST_I         (RST_I),
        .pin_i         (EXT_IRQ_I[g]),
        .falling_sel_i (ctrl_reg[g]),
        .edge_o        (edge_hit[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, mask and outputs.
  // Bits 2..0 are the pin edges, bit 3 the software trap; a set beats a same-cycle clear.
  assign event_set = {ctrl_reg[`BIT_SOFT_TRAP_FLAG], edge_hit};

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      status_reg <= 4'h0;
    end else begin
      status_reg <= (status_reg & ~(wr_status ? HWDATA_I[3:0] : 4'h0)) | event_set;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      mask_reg <= 4'h0;
    end else if (wr_mask) begin
      mask_reg <= HWDATA_I[3:0];
    end
  end

  // Ordinary events need the global enable and no hold-off; the trap does not.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      IRQ_O        <= 1'b0;
      TRAP_REQ_O   <= 1'b0;
      PRIO_LEVEL_O <= 4'h0;
    end else begin
      IRQ_O        <= ctrl_reg[`BIT_GIE] & ~irq_holdoff_active & |(status_reg[2:0] & mask_reg[2:0]);
      TRAP_REQ_O   <= status_reg[`STAT_TRAP] & mask_reg[`STAT_TRAP];
      PRIO_LEVEL_O <= {prio_level_top_bit, CPU_STATUS_PRIO_I};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data; the slave never inserts wait states.
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (HADDR_I)
      `OFS_CTRL:   rdata_next = {16'h0000, ctrl_reg[15], irq_holdoff_active, ctrl_reg[13:0]};
      `OFS_STATUS: rdata_next = {28'h0000000, status_reg};
      `OFS_MASK:   rdata_next = {28'h0000000, mask_reg};
      `OFS_CORE:   rdata_next = {31'h00000000, prio_level_top_bit};
      `OFS_LEVEL:  rdata_next = {28'h0000000, prio_level_top_bit, CPU_STATUS_PRIO_I};
      default:     rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      HRDATA_O    <= 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
      if (start_xfer & ~HWRITE_I) begin
        HRDATA_O <= rdata_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_gie_blocks_irq: assert property (@(posedge CLK_I) disable iff (RST_I)
    !$past(ctrl_reg[`BIT_GIE]) |-> !IRQ_O) else $error("Interrupt raised with global enable cleared.");
  a_holdoff_flag: assert property (@(posedge CLK_I) disable iff (RST_I)
    (HOLDOFF_START_I && HOLDOFF_COUNT_I == 16'h0002) |=> irq_holdoff_active ##1 irq_holdoff_active ##1 !irq_holdoff_active)
    else $error("Hold-off flag length wrong.");
  a_soft_trap: assert property (@(posedge CLK_I) disable iff (RST_I)
    (ctrl_reg[`BIT_SOFT_TRAP_FLAG] && mask_reg[`STAT_TRAP] && !wr_mask) |=> ##1 TRAP_REQ_O)
    else $error("Software trap did not reach the core.");
  a_edge_sets: assert property (@(posedge CLK_I) disable iff (RST_I)
    edge_hit[0] |=> status_reg[0]) else $error("Pin edge did not set status.");
  a_prio_level: assert property (@(posedge CLK_I) disable iff (RST_I)
    PRIO_LEVEL_O == {$past(prio_level_top_bit), $past(CPU_STATUS_PRIO_I)}) else $error("Priority level wrong.");
  a_trap_no_gie: assert property (@(posedge CLK_I) disable iff (RST_I)
    ($past(status_reg[3]) && $past(mask_reg[3])) |-> TRAP_REQ_O) else $error("Trap blocked.");
  a_holdoff_gate: assert property (@(posedge CLK_I) disable iff (RST_I)
    $past(irq_holdoff_active) |-> !IRQ_O) else $error("Interrupt during hold-off.");
  a_ctrl_reserved: assert property (@(posedge CLK_I) disable iff (RST_I)
    ctrl_reg[12:3] == 10'h000) else $error("Reserved control bits set.");
endmodule

//--- verif/irq_far_model.sv
// Model of the pins and the core that face the interrupt control block.
module irq_far_model (
  // Clock.
  input  wire logic        clk_i,
  // Requests from the bench.
  input  wire logic [2:0]  pin_req_i,
  input  wire logic [2:0]  prio_req_i,
  input  wire logic [15:0] hold_req_i,
  // Towards the block.
  output logic [2:0]       pin_o = 3'h0,
  output logic [2:0]       prio_o = 3'h0,
  output logic             hold_start_o = 1'b0,
  output logic [15:0]      hold_count_o = 16'h0
);
  // The count lines are only valid with the start pulse, so they toggle otherwise.
  always @(posedge clk_i) begin
    pin_o <= pin_req_i;
    prio_o <= prio_req_i;
    hold_start_o <= (hold_req_i != 16'h0);
    hold_count_o <= (hold_req_i != 16'h0) ? hold_req_i : ~hold_count_o;
  end
endmodule

//--- verif/tb.sv
// Self-checking bench of the interrupt control block.
`include "irq_ctl_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hresp, trap, irq, hs;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, rdata;
  logic [2:0] pin_req = 3'h0, prio_req = 3'h0, pins, prio;
  logic [15:0] hold_req = 16'h0, hc;
  logic [3:0] lvl;
  int error_cnt = 0, check_count = 0, seed = 69164, n, m;
  initial forever #20 clk = ~clk;
  irq_far_model far (.clk_i(clk), .pin_req_i(pin_req), .prio_req_i(prio_req), .hold_req_i(hold_req),
    .pin_o(pins), .prio_o(prio), .hold_start_o(hs), .hold_count_o(hc));
  irq_ctl dut (.CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(rdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .EXT_IRQ_I(pins), .CPU_STATUS_PRIO_I(prio),
    .HOLDOFF_START_I(hs), .HOLDOFF_COUNT_I(hc), .PRIO_LEVEL_O(lvl), .TRAP_REQ_O(trap), .IRQ_O(irq));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = rdata;
    chk("resp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic close_out;
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #400000;
    error_cnt++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd("ctrl", `OFS_CTRL, 32'h8000);
    rd("unmapped", 8'h20, 32'h0);
    wr(`OFS_MASK, 32'hF);
    // Polarity is swept with the pin idle low, so only the chosen edge may post.
    for (int i = 0; i < 3; i++) begin
      for (int f = 0; f < 2; f++) begin
        wr(`OFS_CTRL, 32'h8000 | (f << i));
        wr(`OFS_STATUS, 32'hF);
        pin_req[i] <= 1'b1;
        repeat (6) @(posedge clk);
        rd("rise", `OFS_STATUS, (1 - f) << i);
        chk("irq", {31'h0, irq}, 32'(1 - f));
        wr(`OFS_STATUS, 32'hF);
        pin_req[i] <= 1'b0;
        repeat (6) @(posedge clk);
        rd("fall", `OFS_STATUS, f << i);
      end
    end
    wr(`OFS_CTRL, 32'h2004);
    repeat (3) @(posedge clk);
    chk("irq_off", {31'h0, irq}, 32'h0);
    chk("trap", {31'h0, trap}, 32'h1);
    rd("ctrl_trap", `OFS_CTRL, 32'h2004);
    rd("stat_trap", `OFS_STATUS, 32'hC);
    wr(`OFS_CTRL, 32'hFFFF);
    wr(`OFS_STATUS, 32'h8);
    rd("ctrl_ro", `OFS_CTRL, 32'hA007);
    wr(`OFS_CTRL, 32'h8004);
    wr(`OFS_STATUS, 32'h8);
    n = 4 + ($unsigned($random(seed)) % 16);
    hold_req <= 16'(n);
    @(posedge clk);
    hold_req <= 16'h0;
    // The start pulse reaches the counter one edge after the model raises it, so the read waits one edge.
    @(posedge clk);
    rd("hold_on", `OFS_CTRL, 32'hC004);
    chk("irq_hold", {31'h0, irq}, 32'h0);
    repeat (n + 2) @(posedge clk);
    rd("hold_off", `OFS_CTRL, 32'h8004);
    chk("irq_on", {31'h0, irq}, 32'h1);
    // A count of two gives the hold-off length check a start to watch.
    hold_req <= 16'h2;
    @(posedge clk);
    hold_req <= 16'h0;
    repeat (6) @(posedge clk);
    rd("hold_two", `OFS_CTRL, 32'h8004);
    for (int k = 0; k < 6; k++) begin
      m = $random(seed);
      prio_req <= m[2:0];
      wr(`OFS_CORE, {31'h0, m[3]});
      repeat (3) @(posedge clk);
      chk("prio", {28'h0, lvl}, {28'h0, m[3], m[2:0]});
      rd("level", `OFS_LEVEL, {28'h0, m[3], m[2:0]});
    end
    close_out;
  end
endmodule
